// *** hdl/esip_consts.vh ***
// Constants for the Ethernet status word and node address selection block.
`ifndef ESIP_CONSTS_VH
`define ESIP_CONSTS_VH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define ESIP_OFF_STATUS 12'h000
`define ESIP_OFF_VERSION 12'h004
`define ESIP_OFF_CTRL 12'h008
`define ESIP_OFF_DEF_ADDR 12'h00c
`define ESIP_OFF_DEF_MASK 12'h010
`define ESIP_OFF_DEF_GW 12'h014
`define ESIP_OFF_ADDR 12'h018
`define ESIP_OFF_MASK 12'h01c
`define ESIP_OFF_GW 12'h020
`define ESIP_OFF_IRQ_STAT 12'h024
`define ESIP_OFF_IRQ_MASK 12'h028
`define ESIP_OFF_LOAD 12'h02c

// ****************************************************************
// Field positions.
// ****************************************************************
`define ESIP_ST_DUPLEX 13
`define ESIP_ST_SPEED 12
`define ESIP_ST_RX 10
`define ESIP_ST_TX 9
`define ESIP_ST_LINK 8
`define ESIP_CTRL_DIR_RW 0
`define ESIP_CTRL_NODE_OPT 1
`define ESIP_CTRL_ADDR_TGT 2
`define ESIP_CTRL_MASK_TGT 3
`define ESIP_CTRL_GW_TGT 4
`define ESIP_LOAD_OK 0
`define ESIP_LOAD_FAIL 1
`define ESIP_IRQ_STATUS 0
`define ESIP_IRQ_ADDR 1
`define ESIP_IRQ_LOAD 2
`define ESIP_IRQ_W 3

// ****************************************************************
// Values.
// ****************************************************************
`define ESIP_MAX_SESSIONS 8'h28
`define ESIP_VER_SCALE 16'h0064
`define ESIP_RST_ADDR 32'hc0a8_0001
`define ESIP_RST_MASK 32'hffff_ff00
`define ESIP_RST_GW 32'h0000_0000
`define ESIP_RST_CTRL 32'h0000_0000

`endif

// *** hdl/esip_nv_store.v ***
// Non-volatile copy of the default address, mask and gateway.
`timescale 1ns/100ps
`include "esip_consts.vh"
module esip_nv_store (
    input wire clk_i,
    input wire rst_i,
    input wire save_i,
    input wire [31:0] addr_i,
    input wire [31:0] mask_i,
    input wire [31:0] gw_i,
    output reg [31:0] addr_o,
    output reg [31:0] mask_o,
    output reg [31:0] gw_o
);
    // Contents survive a failed load; only a good load or a reset rewrites them.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_o <= `ESIP_RST_ADDR;
            mask_o <= `ESIP_RST_MASK;
            gw_o <= `ESIP_RST_GW;
        end else if (save_i) begin
            addr_o <= addr_i;
            mask_o <= mask_i;
            gw_o <= gw_i;
        end
    end
endmodule

// *** hdl/esip_top.v ***
// APB register bank for Ethernet status word, version and node address selection.
`timescale 1ns/100ps
`include "esip_consts.vh"
module esip_top #(
    parameter FW_VERSION_X100 = 16'd430
) (
    input wire SYS_CLK_I,
    input wire RST_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    input wire LINK_DUPLEX_I,
    input wire LINK_SPEED_FLAG_I,
    input wire RX_ACTIVE_I,
    input wire TX_ACTIVE_I,
    input wire LINK_UP_I,
    input wire [7:0] OPEN_SESSION_COUNT_I,
    input wire [7:0] NODE_ID_I,
    output reg [31:0] NODE_ADDR_O,
    output reg [31:0] NODE_MASK_O,
    output reg [31:0] NODE_GW_O,
    output reg [15:0] LINK_STATUS_WORD_O,
    output reg IRQ_O
);

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    function [7:0] clamp_sessions;
        input [7:0] cnt;
        begin
            clamp_sessions = (cnt > `ESIP_MAX_SESSIONS) ? `ESIP_MAX_SESSIONS : cnt;
        end
    endfunction

    function [31:0] merge_word;
        input [31:0] old;
        input [31:0] wdat;
        input hit;
        begin
            merge_word = hit ? wdat : old;
        end
    endfunction

    // Compares a bus address with one register offset.
    function reg_hit;
        input [11:0] addr;
        input [11:0] off;
        begin
            reg_hit = (addr == off);
        end
    endfunction

    // ****************************************************************
    // State.
    // ****************************************************************
    reg [15:0] link_status_word_ff;
    reg [15:0] nxt_link_status_word;
    reg [31:0] ctrl_ff;
    reg [31:0] def_addr_ff;
    reg [31:0] def_mask_ff;
    reg [31:0] def_gw_ff;
    reg [31:0] addr_tgt_ff;
    reg [31:0] mask_tgt_ff;
    reg [31:0] gw_tgt_ff;
    reg [31:0] nxt_addr_tgt;
    reg [31:0] nxt_mask_tgt;
    reg [31:0] nxt_gw_tgt;
    reg [31:0] act_addr;
    reg [31:0] act_mask;
    reg [31:0] act_gw;
    reg [`ESIP_IRQ_W-1:0] irq_stat_ff;
    reg [`ESIP_IRQ_W-1:0] irq_mask_ff;
    reg [`ESIP_IRQ_W-1:0] irq_evt;
    reg load_failed_ff;
    reg nv_save_ff;
    reg [31:0] rdata;
    reg addr_ok;
    wire [31:0] nv_addr;
    wire [31:0] nv_mask;
    wire [31:0] nv_gw;
    wire [15:0] version_word;
    wire acc;
    wire wr;
    wire dir_rw;
    wire node_opt;
    wire wr_done;
    wire wr_addr_tgt;
    wire wr_mask_tgt;
    wire wr_gw_tgt;
    wire wr_load;
    wire wr_irq_stat;
    reg [31:0] base_addr;
    reg [31:0] base_mask;
    reg [31:0] base_gw;

    assign acc = PSEL_I & PENABLE_I;
    assign wr = acc & PWRITE_I;
    assign dir_rw = ctrl_ff[`ESIP_CTRL_DIR_RW];
    assign node_opt = ctrl_ff[`ESIP_CTRL_NODE_OPT] & ~dir_rw;
    assign version_word = FW_VERSION_X100;

    // ****************************************************************
    // Write strobes.
    // ****************************************************************
    // A write lands once, at the answering edge, and never in the wait state.
    assign wr_done = wr & PREADY_O;
    assign wr_addr_tgt = wr_done & reg_hit(PADDR_I, `ESIP_OFF_ADDR);
    assign wr_mask_tgt = wr_done & reg_hit(PADDR_I, `ESIP_OFF_MASK);
    assign wr_gw_tgt = wr_done & reg_hit(PADDR_I, `ESIP_OFF_GW);
    assign wr_load = wr_done & reg_hit(PADDR_I, `ESIP_OFF_LOAD);
    assign wr_irq_stat = wr_done & reg_hit(PADDR_I, `ESIP_OFF_IRQ_STAT);

    esip_nv_store u_nv (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .save_i(nv_save_ff),
        .addr_i(def_addr_ff),
        .mask_i(def_mask_ff),
        .gw_i(def_gw_ff),
        .addr_o(nv_addr),
        .mask_o(nv_mask),
        .gw_o(nv_gw)
    );

    // ****************************************************************
    // Status word, sampled from all inputs in one cycle.
    // ****************************************************************
    always @* begin
        nxt_link_status_word = 16'h0000;
        nxt_link_status_word[`ESIP_ST_DUPLEX] = LINK_DUPLEX_I;
        nxt_link_status_word[`ESIP_ST_SPEED] = LINK_SPEED_FLAG_I;
        nxt_link_status_word[`ESIP_ST_RX] = RX_ACTIVE_I;
        nxt_link_status_word[`ESIP_ST_TX] = TX_ACTIVE_I;
        nxt_link_status_word[`ESIP_ST_LINK] = LINK_UP_I;
        nxt_link_status_word[7:0] = clamp_sessions(OPEN_SESSION_COUNT_I);
    end

    // ****************************************************************
    // Fallback defaults.
    // ****************************************************************
    // The saved copy replaces the live defaults once a load has failed.
    always @* begin
        base_addr = def_addr_ff;
        base_mask = def_mask_ff;
        base_gw = def_gw_ff;
        if (load_failed_ff) begin
            base_addr = nv_addr;
            base_mask = nv_mask;
            base_gw = nv_gw;
        end
    end

    // ****************************************************************
    // Address source selection.
    // ****************************************************************
    // Software owns the address only in read/write direction with its target enabled.
    // The node id replaces the low octet only in read-only direction.
    always @* begin
        act_addr = base_addr;
        act_mask = base_mask;
        act_gw = base_gw;
        if (dir_rw && ctrl_ff[`ESIP_CTRL_ADDR_TGT]) begin
            act_addr = addr_tgt_ff;
        end else if (node_opt) begin
            act_addr = {base_addr[31:8], NODE_ID_I};
        end
        if (dir_rw && ctrl_ff[`ESIP_CTRL_MASK_TGT]) begin
            act_mask = mask_tgt_ff;
        end
        if (dir_rw && ctrl_ff[`ESIP_CTRL_GW_TGT]) begin
            act_gw = gw_tgt_ff;
        end
    end

    // Targets: software owns them in read/write direction, device otherwise.
    always @* begin
        nxt_addr_tgt = addr_tgt_ff;
        nxt_mask_tgt = mask_tgt_ff;
        nxt_gw_tgt = gw_tgt_ff;
        if (dir_rw) begin
            nxt_addr_tgt = merge_word(addr_tgt_ff, PWDATA_I, wr_addr_tgt);
            nxt_mask_tgt = merge_word(mask_tgt_ff, PWDATA_I, wr_mask_tgt);
            nxt_gw_tgt = merge_word(gw_tgt_ff, PWDATA_I, wr_gw_tgt);
        end else begin
            if (ctrl_ff[`ESIP_CTRL_ADDR_TGT]) begin
                nxt_addr_tgt = act_addr;
            end
            if (ctrl_ff[`ESIP_CTRL_MASK_TGT]) begin
                nxt_mask_tgt = act_mask;
            end
            if (ctrl_ff[`ESIP_CTRL_GW_TGT]) begin
                nxt_gw_tgt = act_gw;
            end
        end
    end

    // ****************************************************************
    // Interrupt events.
    // ****************************************************************
    always @* begin
        irq_evt = {`ESIP_IRQ_W{1'b0}};
        irq_evt[`ESIP_IRQ_STATUS] = (nxt_link_status_word != link_status_word_ff);
        irq_evt[`ESIP_IRQ_ADDR] = (act_addr != NODE_ADDR_O);
        irq_evt[`ESIP_IRQ_LOAD] = wr_load & PWDATA_I[`ESIP_LOAD_FAIL];
    end

    // ****************************************************************
    // Read decode.
    // ****************************************************************
    always @* begin
        rdata = 32'h0000_0000;
        addr_ok = 1'b1;
        case (PADDR_I)
            `ESIP_OFF_STATUS: rdata = {16'h0000, link_status_word_ff};
            `ESIP_OFF_VERSION: rdata = {16'h0000, version_word};
            `ESIP_OFF_CTRL: rdata = ctrl_ff;
            `ESIP_OFF_DEF_ADDR: rdata = def_addr_ff;
            `ESIP_OFF_DEF_MASK: rdata = def_mask_ff;
            `ESIP_OFF_DEF_GW: rdata = def_gw_ff;
            `ESIP_OFF_ADDR: rdata = addr_tgt_ff;
            `ESIP_OFF_MASK: rdata = mask_tgt_ff;
            `ESIP_OFF_GW: rdata = gw_tgt_ff;
            `ESIP_OFF_IRQ_STAT: rdata = {29'h0000_0000, irq_stat_ff};
            `ESIP_OFF_IRQ_MASK: rdata = {29'h0000_0000, irq_mask_ff};
            `ESIP_OFF_LOAD: rdata = {31'h0000_0000, load_failed_ff};
            default: addr_ok = 1'b0;
        endcase
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    always @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            link_status_word_ff <= 16'h0000;
            ctrl_ff <= `ESIP_RST_CTRL;
            def_addr_ff <= `ESIP_RST_ADDR;
            def_mask_ff <= `ESIP_RST_MASK;
            def_gw_ff <= `ESIP_RST_GW;
            addr_tgt_ff <= 32'h0000_0000;
            mask_tgt_ff <= 32'h0000_0000;
            gw_tgt_ff <= 32'h0000_0000;
            irq_stat_ff <= {`ESIP_IRQ_W{1'b0}};
            irq_mask_ff <= {`ESIP_IRQ_W{1'b0}};
            load_failed_ff <= 1'b0;
            nv_save_ff <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            NODE_ADDR_O <= `ESIP_RST_ADDR;
            NODE_MASK_O <= `ESIP_RST_MASK;
            NODE_GW_O <= `ESIP_RST_GW;
            LINK_STATUS_WORD_O <= 16'h0000;
            IRQ_O <= 1'b0;
        end else begin
            // Refreshed every cycle regardless of host run state.
            link_status_word_ff <= nxt_link_status_word;
            LINK_STATUS_WORD_O <= nxt_link_status_word;
            addr_tgt_ff <= nxt_addr_tgt;
            mask_tgt_ff <= nxt_mask_tgt;
            gw_tgt_ff <= nxt_gw_tgt;
            NODE_ADDR_O <= act_addr;
            NODE_MASK_O <= act_mask;
            NODE_GW_O <= act_gw;
            nv_save_ff <= 1'b0;
            // Access phase answers one cycle after it starts: pready pulses.
            PREADY_O <= acc & ~PREADY_O;
            PSLVERR_O <= acc & ~PREADY_O & ~addr_ok;
            if (acc && !PREADY_O && !PWRITE_I) begin
                PRDATA_O <= rdata;
            end
            // Writes land at the edge where pready is seen high.
            if (wr_done) begin
                case (PADDR_I)
                    `ESIP_OFF_CTRL: ctrl_ff <= PWDATA_I;
                    `ESIP_OFF_DEF_ADDR: def_addr_ff <= PWDATA_I;
                    `ESIP_OFF_DEF_MASK: def_mask_ff <= PWDATA_I;
                    `ESIP_OFF_DEF_GW: def_gw_ff <= PWDATA_I;
                    `ESIP_OFF_IRQ_MASK: irq_mask_ff <= PWDATA_I[`ESIP_IRQ_W-1:0];
                    `ESIP_OFF_LOAD: begin
                        if (PWDATA_I[`ESIP_LOAD_OK]) begin
                            nv_save_ff <= 1'b1;
                            load_failed_ff <= 1'b0;
                        end else if (PWDATA_I[`ESIP_LOAD_FAIL]) begin
                            load_failed_ff <= 1'b1;
                        end
                    end
                    // Status and version writes are ignored.
                    default: ctrl_ff <= ctrl_ff;
                endcase
            end
            // Set wins over write-one-to-clear.
            if (wr_irq_stat) begin
                irq_stat_ff <= (irq_stat_ff & ~PWDATA_I[`ESIP_IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_stat_ff <= irq_stat_ff | irq_evt;
            end
            IRQ_O <= |(irq_stat_ff & irq_mask_ff);
        end
    end
endmodule

// *** verif/esip_chk.sv ***
// Concurrent checks on the status word and the APB answers of esip_top.
`timescale 1ns/100ps
module esip_chk #(
    parameter FW_VERSION_X100 = 16'd430
) (
    input wire SYS_CLK_I,
    input wire RST_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PRDATA_O,
    input wire PREADY_O,
    input wire PSLVERR_O,
    input wire LINK_DUPLEX_I,
    input wire LINK_SPEED_FLAG_I,
    input wire RX_ACTIVE_I,
    input wire TX_ACTIVE_I,
    input wire LINK_UP_I,
    input wire [7:0] OPEN_SESSION_COUNT_I,
    input wire [15:0] LINK_STATUS_WORD_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    // ****************************************************************
    // Status word and register answers.
    // ****************************************************************
    property p_zero_bits;
        LINK_STATUS_WORD_O[15:14] == 2'b00 && !LINK_STATUS_WORD_O[11];
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("reserved status bit set");
    property p_flags;
        !$past(RST_I) |-> LINK_STATUS_WORD_O[13:8] == {$past(LINK_DUPLEX_I),
            $past(LINK_SPEED_FLAG_I), 1'b0, $past(RX_ACTIVE_I), $past(TX_ACTIVE_I),
            $past(LINK_UP_I)};
    endproperty
    a_flags: assert property (p_flags)
        else $error("status flags do not follow inputs");
    property p_count;
        !$past(RST_I) |-> LINK_STATUS_WORD_O[7:0] == (($past(OPEN_SESSION_COUNT_I) > 8'h28) ?
            8'h28 : $past(OPEN_SESSION_COUNT_I));
    endproperty
    a_count: assert property (p_count)
        else $error("session count field wrong");
    property p_ver;
        PREADY_O && !PWRITE_I && PADDR_I == 12'h004 |-> PRDATA_O == FW_VERSION_X100;
    endproperty
    a_ver: assert property (p_ver)
        else $error("version read wrong");
    property p_wait;
        PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O;
    endproperty
    a_wait: assert property (p_wait)
        else $error("no answer after access phase");
    property p_once;
        PREADY_O |=> !PREADY_O;
    endproperty
    a_once: assert property (p_once)
        else $error("ready held too long");
    property p_idle;
        !PSEL_I |=> !PREADY_O;
    endproperty
    a_idle: assert property (p_idle)
        else $error("ready without select");
    property p_err;
        PREADY_O && PADDR_I[1:0] == 2'b00 |-> PSLVERR_O == (PADDR_I > 12'h02c);
    endproperty
    a_err: assert property (p_err)
        else $error("error response wrong");
    property p_rdz;
        PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0;
    endproperty
    a_rdz: assert property (p_rdz)
        else $error("unmapped read data not zero");
endmodule
bind esip_top esip_chk #(.FW_VERSION_X100(FW_VERSION_X100)) u_esip_chk (.*);

// *** verif/esip_link_model.sv ***
// Model of the link side that feeds flags and session count into the block.
`timescale 1ns/100ps
module esip_link_model (
    input wire clk_i,
    input wire upd_i,
    input wire [12:0] val_i,
    output reg [12:0] link_o
);
    initial link_o = 13'h0000;
    // Bits are duplex, speed, rx, tx, link, then the count byte.
    always @(posedge clk_i) begin
        if (upd_i) begin
            link_o <= val_i;
        end
    end
endmodule

// *** verif/esip_top_tb.sv ***
// Self-checking bench for the status word, version and node address block.
`timescale 1ns/100ps
`include "esip_consts.vh"
module esip_top_tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg pen = 1'b0;
    reg pwr = 1'b0;
    reg [11:0] pa = 12'h000;
    reg [31:0] pwd = 32'h0;
    reg [7:0] nid = 8'h00;
    reg upd = 1'b0;
    reg [12:0] lval = 13'h0000;
    reg [31:0] rd, x;
    reg err;
    wire [12:0] lnk;
    wire [31:0] prd, n_addr, n_mask, n_gw;
    wire prdy, perr, irq;
    wire [15:0] stw;
    integer seed = 87352;
    integer n_fail = 0;
    integer total_checks = 0;
    integer i;
    initial forever #2 clk = ~clk;
    esip_link_model u_esip_link_model (.clk_i(clk), .upd_i(upd), .val_i(lval), .link_o(lnk));
    esip_top u_esip_top (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
        .PSLVERR_O(perr), .LINK_DUPLEX_I(lnk[12]), .LINK_SPEED_FLAG_I(lnk[11]),
        .RX_ACTIVE_I(lnk[10]), .TX_ACTIVE_I(lnk[9]), .LINK_UP_I(lnk[8]),
        .OPEN_SESSION_COUNT_I(lnk[7:0]), .NODE_ID_I(nid), .NODE_ADDR_O(n_addr),
        .NODE_MASK_O(n_mask), .NODE_GW_O(n_gw), .LINK_STATUS_WORD_O(stw), .IRQ_O(irq));
    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwr <= w;
            pa <= a;
            pwd <= d;
            @(posedge clk);
            pen <= 1'b1;
            for (k = 0; k < 20 && prdy !== 1'b1; k = k + 1)
                @(posedge clk);
            if (k == 20) begin
                chk(32'h0, 32'h1);
                report_and_stop;
            end
            rd = prd;
            err = perr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    function [15:0] st_exp(input [12:0] v);
        st_exp = {2'b00, v[12:11], 1'b0, v[10:8], (v[7:0] > 8'h28) ? 8'h28 : v[7:0]};
    endfunction
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(n_mask, `ESIP_RST_MASK);
        for (i = 0; i < 24; i = i + 1) begin
            x = $random(seed);
            if (i == 0)
                x = 32'h1fff;
            if (i == 1)
                x = 32'h0028;
            @(posedge clk);
            lval <= x[12:0];
            upd <= 1'b1;
            @(posedge clk);
            upd <= 1'b0;
            repeat (2) @(posedge clk);
            chk(stw, st_exp(x[12:0]));
            apb(1'b0, `ESIP_OFF_STATUS, 32'h0);
            chk(rd, st_exp(x[12:0]));
        end
        $display("status word test done");
        apb(1'b1, `ESIP_OFF_STATUS, 32'hffff);
        apb(1'b0, `ESIP_OFF_STATUS, 32'h0);
        chk(rd, st_exp(x[12:0]));
        apb(1'b1, `ESIP_OFF_VERSION, 32'h1);
        apb(1'b0, `ESIP_OFF_VERSION, 32'h0);
        chk(rd, 32'd430);
        apb(1'b0, 12'h030, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `ESIP_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `ESIP_OFF_IRQ_STAT, 32'h7);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("register and interrupt test done");
        x = $random(seed);
        nid <= x[7:0];
        apb(1'b1, `ESIP_OFF_DEF_ADDR, 32'h0a0b0c0d);
        apb(1'b1, `ESIP_OFF_CTRL, 32'h4);
        repeat (3) @(posedge clk);
        chk(n_addr, 32'h0a0b0c0d);
        apb(1'b0, `ESIP_OFF_ADDR, 32'h0);
        chk(rd, 32'h0a0b0c0d);
        apb(1'b1, `ESIP_OFF_CTRL, 32'h6);
        repeat (3) @(posedge clk);
        chk(n_addr, {24'h0a0b0c, nid});
        apb(1'b0, `ESIP_OFF_ADDR, 32'h0);
        chk(rd, {24'h0a0b0c, nid});
        apb(1'b1, `ESIP_OFF_CTRL, 32'h7);
        for (i = 0; i < 3; i = i + 1) begin
            x = $random(seed);
            apb(1'b1, `ESIP_OFF_ADDR, x);
            repeat (3) @(posedge clk);
            chk(n_addr, x);
        end
        apb(1'b1, `ESIP_OFF_CTRL, 32'h1d);
        x = $random(seed);
        apb(1'b1, `ESIP_OFF_MASK, x);
        apb(1'b1, `ESIP_OFF_GW, ~x);
        repeat (3) @(posedge clk);
        chk(n_mask, x);
        chk(n_gw, ~x);
        apb(1'b1, `ESIP_OFF_CTRL, 32'h18);
        apb(1'b0, `ESIP_OFF_MASK, 32'h0);
        chk(rd, `ESIP_RST_MASK);
        $display("address source test done");
        apb(1'b1, `ESIP_OFF_DEF_MASK, 32'hffff0000);
        apb(1'b1, `ESIP_OFF_DEF_GW, 32'h0a0b0c01);
        apb(1'b1, `ESIP_OFF_LOAD, 32'h1);
        apb(1'b1, `ESIP_OFF_DEF_ADDR, 32'h11223344);
        apb(1'b1, `ESIP_OFF_DEF_GW, 32'h0);
        apb(1'b1, `ESIP_OFF_CTRL, 32'h0);
        apb(1'b1, `ESIP_OFF_LOAD, 32'h2);
        repeat (3) @(posedge clk);
        chk(n_addr, 32'h0a0b0c0d);
        chk(n_mask, 32'hffff0000);
        chk(n_gw, 32'h0a0b0c01);
        apb(1'b0, `ESIP_OFF_LOAD, 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'b1, `ESIP_OFF_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, `ESIP_OFF_IRQ_STAT, 32'h0);
        chk(rd, 32'h6);
        $display("saved defaults test done");
        report_and_stop;
    end
endmodule
